/* File: verilog/swfg_square_wave_gen.sv */
// square wave generator with APB registers, sync and enable pins
//
// Overview of operation
// - output frequency equals command in 0.1 Hz units, valid range 1 to 1,000,000
// - generator runs only while the enable command bit is set
// - with authorization and a configured pin, the enable pin must also be high
// - authorized sync on a configured pin restarts the period timer
// - a rising edge of the resync bit restarts the period timer
// - at-frequency is true only while the wave is really produced at command
// - at-frequency false when unreachable, disabled or enable pin gating fails
// - busy rises when enabled and a frequency change is in progress
// - busy clears on at-frequency, on fault, or when enable drops
// - fault flag shows a detected fault, fault code tells its type
// - unreachable frequency lowers at-frequency without raising fault
// - wave, at-frequency, busy, fault and fault code outputs are forced low while the controller is halted
// - accepted sync edge aborts the running cycle and starts a new one
// - sync edge selectable rising, falling or both, rising after reset
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module swfg_square_wave_gen #(
   parameter int FREQ_W = swfg_pkg::FREQ_W,
   parameter int HALF_W = swfg_pkg::HALF_W
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [swfg_pkg::APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halted_state,
   input wire logic ext_enable_pin,
   input wire logic sync_pin,
   output logic square_out,
   output logic at_target_freq,
   output logic busy,
   output logic fault,
   output swfg_pkg::swfg_fault_code_type fault_code
);
   import swfg_pkg::*;

   generate
      if (FREQ_W != swfg_pkg::FREQ_W || HALF_W < swfg_pkg::HALF_W) begin : g_bad
         $error("swfg_square_wave_gen: widths cannot serve the command range");
      end
   endgenerate

   // ==========================================================
   // declarations
   // ==========================================================
   logic [CTRL_W-1:0] ctrl_r;
   logic [FREQ_W-1:0] freq_r;
   logic [31:0] prdata_r;
   logic [HALF_W-1:0] half_r;
   logic half_valid_r;
   logic [HALF_W-1:0] cnt_r;
   logic square_r;
   logic at_freq_r;
   logic busy_r;
   logic fault_r;
   swfg_fault_code_type code_r;
   logic sync_d_r;
   logic resync_d_r;

   logic setup;
   logic access;
   logic hit_ctrl;
   logic hit_freq;
   logic hit_status;
   logic wr_ctrl;
   logic wr_freq;
   logic wdata_ok;
   logic freq_ok;
   logic start_div;
   logic div_busy;
   logic div_done;
   logic [HALF_W-1:0] div_q;
   swfg_edge_type edge_sel;
   logic edge_bad;
   logic sync_rise;
   logic sync_fall;
   logic sync_edge;
   logic sync_hit;
   logic resync_rise;
   logic pin_gate;
   logic run;
   logic run_ok;
   logic restart;
   logic wrap;
   logic at_freq_nxt;
   logic busy_nxt;
   logic fault_nxt;
   logic [31:0] status_word;

   // ==========================================================
   // APB slave
   // ==========================================================
   // zero wait states: every access completes in its first access cycle
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign hit_ctrl = (paddr == ADDR_CTRL);
   assign hit_freq = (paddr == ADDR_FREQ);
   assign hit_status = (paddr == ADDR_STATUS);
   assign pready = 1'b1;
   assign pslverr = access & ~(hit_ctrl | hit_freq | hit_status);
   assign wr_ctrl = access & pwrite & hit_ctrl;
   assign wr_freq = access & pwrite & hit_freq;
   assign prdata = prdata_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= pwdata[CTRL_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         freq_r <= FREQ_RST;
      end else if (wr_freq) begin
         freq_r <= pwdata[FREQ_W-1:0];
      end
   end

   always_comb begin
      status_word = '0;
      status_word[ST_AT_FREQ] = at_freq_r;
      status_word[ST_BUSY] = busy_r;
      status_word[ST_FAULT] = fault_r;
      status_word[ST_CODE_LO +: 2] = code_r;
      status_word[ST_LEVEL] = square_r;
      status_word[ST_RUN] = run_ok;
   end

   // read data is captured in the setup cycle and held through access
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_r <= 32'h00000000;
      end else if (setup & ~pwrite) begin
         if (hit_ctrl) begin
            prdata_r <= {{(32 - CTRL_W){1'b0}}, ctrl_r};
         end else if (hit_freq) begin
            prdata_r <= {{(32 - FREQ_W){1'b0}}, freq_r};
         end else if (hit_status) begin
            prdata_r <= status_word;
         end else begin
            prdata_r <= 32'h00000000;
         end
      end
   end

   // ==========================================================
   // frequency to half period
   // ==========================================================
   assign wdata_ok = (pwdata[FREQ_W-1:0] >= FREQ_MIN) && (pwdata[FREQ_W-1:0] <= FREQ_MAX)
      && (pwdata[31:FREQ_W] == '0);
   assign freq_ok = (freq_r >= FREQ_MIN) && (freq_r <= FREQ_MAX);
   // out-of-range values never start a division, so the wave stops
   assign start_div = wr_freq & wdata_ok;

   swfg_divider #(
      .DW(FREQ_W),
      .QW(HALF_W),
      .NUM(HALF_NUM)
   ) u_div (
      .clk(clk),
      .reset_n(reset_n),
      .start(start_div),
      .divisor(pwdata[FREQ_W-1:0]),
      .busy(div_busy),
      .done(div_done),
      .quotient(div_q)
   );

   // a new command invalidates the old period until the divider is done
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         half_r <= '0;
         half_valid_r <= 1'b0;
      end else if (wr_freq) begin
         half_valid_r <= 1'b0;
      end else if (div_done && freq_ok) begin
         // a division left running under an out-of-range command must not revive the old period
         half_r <= div_q;
         half_valid_r <= 1'b1;
      end
   end

   // ==========================================================
   // enable, sync and resync
   // ==========================================================
   assign edge_sel = swfg_edge_type'(ctrl_r[CTRL_EDGE_LO +: 2]);
   assign edge_bad = (edge_sel == EDGE_BAD);
   assign sync_rise = sync_pin & ~sync_d_r;
   assign sync_fall = ~sync_pin & sync_d_r;

   always_comb begin
      unique case (edge_sel)
         EDGE_RISE: sync_edge = sync_rise;
         EDGE_FALL: sync_edge = sync_fall;
         EDGE_BOTH: sync_edge = sync_rise | sync_fall;
         EDGE_BAD: sync_edge = 1'b0;
      endcase
   end

   assign sync_hit = ctrl_r[CTRL_SYNC_AUTH] & ctrl_r[CTRL_SYNC_CFG] & sync_edge;
   // software must write the bit low again before the next restart
   assign resync_rise = ctrl_r[CTRL_RESYNC] & ~resync_d_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_d_r <= 1'b0;
         resync_d_r <= 1'b0;
      end else begin
         sync_d_r <= sync_pin;
         resync_d_r <= ctrl_r[CTRL_RESYNC];
      end
   end

   // an enable pin that is configured needs authorization and a high level
   assign pin_gate = ~ctrl_r[CTRL_EN_PIN_CFG] | (ctrl_r[CTRL_EXT_AUTH] & ext_enable_pin);
   assign run = ctrl_r[CTRL_GEN_EN] & pin_gate & ~halted_state & ~edge_bad;
   assign run_ok = run & half_valid_r & freq_ok;
   assign restart = sync_hit | resync_rise;

   // ==========================================================
   // period timer and output wave
   // ==========================================================
   // >= rather than == so a shorter new period cannot overrun the counter
   assign wrap = (cnt_r >= half_r - HALF_W'(1));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= '0;
         square_r <= 1'b0;
      end else if (!run_ok) begin
         cnt_r <= '0;
         square_r <= 1'b0;
      end else if (restart) begin
         cnt_r <= '0;
         square_r <= 1'b1;
      end else if (wrap) begin
         cnt_r <= '0;
         square_r <= ~square_r;
      end else begin
         cnt_r <= cnt_r + HALF_W'(1);
      end
   end

   // ==========================================================
   // status flags
   // ==========================================================
   assign fault_nxt = edge_bad & ~halted_state;
   // the cycle that writes a new command is already off target, so busy can rise at once
   assign at_freq_nxt = run_ok & ~div_busy & ~wr_freq;

   always_comb begin
      busy_nxt = busy_r;
      if (halted_state || !ctrl_r[CTRL_GEN_EN]) begin
         busy_nxt = 1'b0;
      end else if (at_freq_nxt || fault_nxt) begin
         busy_nxt = 1'b0;
      end else if (start_div || div_busy) begin
         busy_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         at_freq_r <= 1'b0;
         busy_r <= 1'b0;
         fault_r <= 1'b0;
         code_r <= FAULT_NONE;
      end else begin
         at_freq_r <= at_freq_nxt;
         busy_r <= busy_nxt;
         fault_r <= fault_nxt;
         code_r <= fault_nxt ? FAULT_BAD_EDGE : FAULT_NONE;
      end
   end

   assign square_out = square_r;
   assign at_target_freq = at_freq_r;
   assign busy = busy_r;
   assign fault = fault_r;
   assign fault_code = code_r;

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_range_reject: assert property ((wr_freq && !wdata_ok) |=> (!half_valid_r)[*2])
      else $error("out-of-range command produced a period");
   a_enable_needed: assert property (!ctrl_r[CTRL_GEN_EN] |=> !square_out && !at_target_freq)
      else $error("wave or at-frequency while disabled");
   a_pin_gate: assert property ((ctrl_r[CTRL_EN_PIN_CFG] && !ext_enable_pin) |=> !square_out)
      else $error("wave while enable pin low");
   a_sync_restart: assert property ((run_ok && sync_hit) |=> square_out && cnt_r == '0)
      else $error("sync edge did not restart the cycle");
   a_resync_start: assert property ((run_ok && resync_rise && !sync_hit) |=> square_out && cnt_r == '0)
      else $error("resync did not restart the cycle");
   a_at_freq_cause: assert property (at_target_freq |-> $past(run_ok) && $past(half_valid_r))
      else $error("at-frequency without a running wave");
   a_at_freq_off: assert property ((!freq_ok || wr_freq) |=> !at_target_freq)
      else $error("at-frequency with unreachable or changing command");
   a_busy_rises: assert property ((start_div && ctrl_r[CTRL_GEN_EN] && !halted_state && !edge_bad)
      |=> busy)
      else $error("busy missing during frequency change");
   a_busy_clears: assert property ((at_target_freq || fault) |-> !busy)
      else $error("busy together with at-frequency or fault");
   a_fault_code: assert property (fault |-> fault_code == FAULT_BAD_EDGE)
      else $error("fault without its code");
   a_range_no_fault: assert property (!edge_bad |=> !fault)
      else $error("fault raised without a fault cause");
   a_halt_zero: assert property (halted_state |=> !square_out && !at_target_freq && !busy && !fault)
      else $error("outputs not zero while halted");
   a_half_period: assert property ((run_ok && !restart && wrap && $stable(half_r))
      |=> square_out != $past(square_out))
      else $error("wave did not toggle at half period");
   // the checks below tie each output to the state that must cause it
   a_idle_low: assert property (!run_ok |=> !square_out)
      else $error("wave high while not running");
   a_code_none: assert property (!fault |-> fault_code == FAULT_NONE)
      else $error("fault code without a fault");
   a_period_load: assert property ((div_done && !wr_freq && freq_ok)
      |=> half_valid_r && half_r == $past(div_q))
      else $error("finished division not taken as period");
   a_stale_div: assert property ((div_done && !freq_ok) |=> !half_valid_r)
      else $error("stale division revived a period");
   a_busy_release: assert property (!ctrl_r[CTRL_GEN_EN] |=> !busy)
      else $error("busy while disabled");
   a_at_freq_gate: assert property (!pin_gate |=> !at_target_freq)
      else $error("at-frequency with enable pin gating closed");

   c_reach_freq: cover property (start_div ##[1:40] at_target_freq);
   c_sync_abort: cover property (at_target_freq && sync_hit ##1 square_out);
   c_busy_walk: cover property (busy ##1 busy[*3] ##[1:40] !busy);
   c_halted: cover property (at_target_freq ##1 halted_state);
   c_resync: cover property (run_ok && resync_rise ##1 square_out);

endmodule : swfg_square_wave_gen

/* File: verilog/swfg_pkg.sv */
// shared constants and types of the square wave frequency generator
package swfg_pkg;

   // ==========================================================
   // clock and frequency scaling
   // ==========================================================
   localparam int CLK_HZ = 25_000_000;
   // command unit is 0.1 Hz, so ten units per hertz
   localparam int FREQ_UNITS_PER_HZ = 10;
   // half period in clocks = HALF_NUM / command value
   localparam int HALF_NUM = CLK_HZ * FREQ_UNITS_PER_HZ / 2;
   localparam int FREQ_W = 20;
   localparam int HALF_W = 27;
   localparam logic [FREQ_W-1:0] FREQ_MIN = 20'h00001;
   localparam logic [FREQ_W-1:0] FREQ_MAX = 20'hF4240;

   // ==========================================================
   // register map
   // ==========================================================
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] ADDR_FREQ = 8'h04;
   localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h08;
   localparam int CTRL_W = 8;
   localparam int CTRL_GEN_EN = 0;
   localparam int CTRL_EXT_AUTH = 1;
   localparam int CTRL_SYNC_AUTH = 2;
   localparam int CTRL_RESYNC = 3;
   localparam int CTRL_EDGE_LO = 4;
   localparam int CTRL_EN_PIN_CFG = 6;
   localparam int CTRL_SYNC_CFG = 7;
   localparam int ST_AT_FREQ = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_CODE_LO = 4;
   localparam int ST_LEVEL = 6;
   localparam int ST_RUN = 7;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
   localparam logic [FREQ_W-1:0] FREQ_RST = 20'h00000;

   // ==========================================================
   // enumerations
   // ==========================================================
   typedef enum logic [1:0] {
      EDGE_RISE = 2'b00,
      EDGE_FALL = 2'b01,
      EDGE_BOTH = 2'b10,
      EDGE_BAD = 2'b11
   } swfg_edge_type;

   typedef enum logic [1:0] {
      FAULT_NONE = 2'b00,
      FAULT_BAD_EDGE = 2'b01
   } swfg_fault_code_type;

   typedef enum logic {
      DIV_IDLE = 1'b0,
      DIV_RUN = 1'b1
   } swfg_div_state_type;

endpackage : swfg_pkg

/* File: verilog/swfg_divider.sv */
// serial divider that turns a command frequency into a half period count
`timescale 1ns/1ps
module swfg_divider #(
   parameter int DW = 20,
   parameter int QW = 27,
   parameter longint NUM = 125_000_000
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [DW-1:0] divisor,
   output logic busy,
   output logic done,
   output logic [QW-1:0] quotient
);
   import swfg_pkg::*;

   localparam int CW = $clog2(QW + 1);

   generate
      if (DW < 1 || QW < 2 || NUM >= (64'h1 << QW)) begin : g_bad
         $error("swfg_divider: widths cannot hold the quotient");
      end
   endgenerate

   swfg_div_state_type state_r;
   logic [CW-1:0] cnt_r;
   logic [DW-1:0] rem_r;
   logic [DW-1:0] dvs_r;
   logic [QW-1:0] num_r;
   logic done_r;
   logic [DW:0] trial;
   logic [DW:0] diff;
   logic ge;

   // one quotient bit per clock, restoring form
   assign trial = {rem_r, num_r[QW-1]};
   assign ge = trial >= {1'b0, dvs_r};
   assign diff = trial - {1'b0, dvs_r};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= DIV_IDLE;
         cnt_r <= '0;
         rem_r <= '0;
         dvs_r <= '0;
         num_r <= '0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            state_r <= DIV_RUN;
            cnt_r <= '0;
            rem_r <= '0;
            dvs_r <= divisor;
            num_r <= NUM[QW-1:0];
         end else begin
            unique case (state_r)
               DIV_IDLE: begin
               end
               DIV_RUN: begin
                  rem_r <= ge ? diff[DW-1:0] : trial[DW-1:0];
                  num_r <= {num_r[QW-2:0], ge};
                  cnt_r <= cnt_r + CW'(1);
                  if (cnt_r == CW'(QW - 1)) begin
                     state_r <= DIV_IDLE;
                     done_r <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   assign busy = (state_r == DIV_RUN);
   assign done = done_r;
   assign quotient = num_r;

endmodule : swfg_divider

/* File: verif/swfg_app_master.sv */
// application side apb master model that drives the generator registers
`timescale 1ns/1ps
module swfg_app_master (
   input wire logic clk,
   output logic [swfg_pkg::APB_AW-1:0] paddr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import swfg_pkg::*;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // ==========================================================
   // one transfer: setup, access held until pready, then release
   // ==========================================================
   task automatic xfer(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show the inverse so stale values are never trusted
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : swfg_app_master

/* File: verif/test_square_wave_freq_generator.sv */
// self-checking bench of the square wave generator
`timescale 1ns/1ps
module test_square_wave_freq_generator;
   import swfg_pkg::*;
   localparam logic [31:0] GEN = 32'h1 << CTRL_GEN_EN;
   localparam logic [31:0] EXT = 32'h1 << CTRL_EXT_AUTH;
   localparam logic [31:0] SAU = 32'h1 << CTRL_SYNC_AUTH;
   localparam logic [31:0] RSY = 32'h1 << CTRL_RESYNC;
   localparam logic [31:0] PIN = 32'h1 << CTRL_EN_PIN_CFG;
   localparam logic [31:0] SCF = 32'h1 << CTRL_SYNC_CFG;
   localparam int HALF_MAX = HALF_NUM / FREQ_MAX;
   logic clk, reset_n, halted_state, ext_enable_pin, sync_pin;
   logic [APB_AW-1:0] paddr;
   logic psel, penable, pwrite, pready, pslverr, err, hit;
   logic [31:0] pwdata, prdata, rd;
   logic square_out, at_target_freq, busy, fault;
   swfg_fault_code_type fault_code;
   int mismatches = 0;
   int n_compared = 0;

   swfg_square_wave_gen i_dut (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .halted_state(halted_state), .ext_enable_pin(ext_enable_pin), .sync_pin(sync_pin),
      .square_out(square_out), .at_target_freq(at_target_freq), .busy(busy), .fault(fault),
      .fault_code(fault_code));
   swfg_app_master i_app (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // ==========================================================
   // helpers
   // ==========================================================
   task automatic finish_test();
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
      i_app.xfer(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rdchk(input logic [APB_AW-1:0] a, input logic [31:0] exp, input logic experr);
      i_app.xfer(1'b0, a, 32'h00000000, rd, err);
      check(rd, exp, "read data");
      check(err, experr, "read error");
   endtask : rdchk
   task automatic wait_lvl(input logic v, input int n);
      hit = 1'b0;
      for (int i = 0; i < n && !hit; i++) begin
         tick(1);
         hit = (square_out === v);
      end
   endtask : wait_lvl
   task automatic wait_at(input int n);
      hit = 1'b0;
      for (int i = 0; i < n && !hit; i++) begin
         tick(1);
         hit = (at_target_freq === 1'b1);
      end
   endtask : wait_at
   task automatic wait_fall();
      wait_lvl(1'b1, 300);
      wait_lvl(1'b0, 300);
   endtask : wait_fall

   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic t_regs();
      check({square_out, at_target_freq, busy, fault}, 0, "outputs idle");
      rdchk(ADDR_CTRL, 32'h00000000, 1'b0);
      rdchk(ADDR_STATUS, 32'h00000000, 1'b0);
      wr(8'h0C, 32'h000000FF);
      check(err, 1'b1, "unmapped write");
      rdchk(8'h0C, 32'h00000000, 1'b1);
      wr(ADDR_STATUS, 32'h000000FF);
      rdchk(ADDR_STATUS, 32'h00000000, 1'b0);
      rdchk(ADDR_FREQ, 32'h00000000, 1'b0);
   endtask : t_regs
   task automatic t_rate();
      int n;
      wr(ADDR_CTRL, GEN);
      wr(ADDR_FREQ, FREQ_MAX);
      tick(2);
      check(busy, 1'b1, "busy in change");
      wait_at(60);
      check(hit, 1'b1, "at target");
      tick(1);
      check({busy, fault}, 0, "busy clear");
      wait_fall();
      wait_lvl(1'b1, 300);
      n = 0;
      while (square_out === 1'b1 && n < 1000) begin
         tick(1);
         n++;
      end
      check(n, HALF_MAX, "high half");
      n = 0;
      while (square_out === 1'b0 && n < 1000) begin
         tick(1);
         n++;
      end
      check(n, HALF_MAX, "low half");
      i_app.xfer(1'b0, ADDR_STATUS, 32'h00000000, rd, err);
      check(rd & 32'h00000087, 32'h00000081, "status running");
      wr(ADDR_FREQ, FREQ_MAX + 1);
      tick(3);
      check({at_target_freq, fault, square_out}, 0, "unreachable");
      wr(ADDR_FREQ, FREQ_MIN);
      wait_at(60);
      check(hit, 1'b1, "lowest rate");
   endtask : t_rate
   task automatic t_enable();
      wr(ADDR_FREQ, FREQ_MAX);
      wr(ADDR_CTRL, GEN | EXT | PIN);
      tick(40);
      check({at_target_freq, square_out}, 0, "pin low gates");
      @(posedge clk) ext_enable_pin <= 1'b1;
      wait_at(60);
      check(hit, 1'b1, "pin high runs");
      wr(ADDR_CTRL, GEN | PIN);
      tick(3);
      check(at_target_freq, 1'b0, "no authorization");
      wr(ADDR_CTRL, 32'h00000000);
      tick(3);
      check({at_target_freq, busy, square_out}, 0, "disabled");
   endtask : t_enable
   task automatic t_sync();
      logic acc;
      for (int e = 0; e < 3; e++) begin
         for (int k = 0; k < 2; k++) begin
            acc = (e == 2) || (e == k);
            wr(ADDR_CTRL, GEN | SAU | SCF | (e << CTRL_EDGE_LO));
            wait_fall();
            @(posedge clk) sync_pin <= ~sync_pin;
            wait_lvl(1'b1, 4);
            check(hit, acc, "sync restart");
         end
      end
      wr(ADDR_CTRL, GEN | SCF | (2 << CTRL_EDGE_LO));
      wait_fall();
      @(posedge clk) sync_pin <= ~sync_pin;
      wait_lvl(1'b1, 4);
      check(hit, 1'b0, "sync not authorized");
      wr(ADDR_CTRL, GEN | SAU | SCF | (3 << CTRL_EDGE_LO));
      tick(3);
      check({fault, fault_code}, {1'b1, FAULT_BAD_EDGE}, "bad edge fault");
   endtask : t_sync
   task automatic t_halt();
      @(posedge clk) halted_state <= 1'b1;
      tick(3);
      check({square_out, at_target_freq, busy, fault, fault_code}, 0, "halted");
      @(posedge clk) halted_state <= 1'b0;
      tick(3);
      check(fault, 1'b1, "fault back");
      wr(ADDR_CTRL, GEN);
      tick(3);
      check({fault, fault_code}, 0, "fault cleared");
   endtask : t_halt
   task automatic t_resync();
      wait_at(60);
      wait_fall();
      wr(ADDR_CTRL, GEN | RSY);
      wait_lvl(1'b1, 6);
      check(hit, 1'b1, "resync rise");
      wait_fall();
      wr(ADDR_CTRL, GEN | RSY);
      wait_lvl(1'b1, 6);
      check(hit, 1'b0, "resync level");
   endtask : t_resync

   // ==========================================================
   // clock, watchdog, main sequence
   // ==========================================================
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #2_000_000;
      mismatches++;
      finish_test();
   end
   initial begin
      reset_n = 1'b0;
      halted_state = 1'b0;
      ext_enable_pin = 1'b0;
      sync_pin = 1'b0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      tick(1);
      t_regs();
      t_rate();
      t_enable();
      t_sync();
      t_halt();
      t_resync();
      finish_test();
   end
endmodule : test_square_wave_freq_generator
